// *** hw/p1bc_defines.svh ***
// Purpose: Offsets, field positions and reset values of the port 1 basic control bank.
// Assumes: 16-bit register words, byte addresses as printed.
// Notes:   Macros only; types live in p1bc_pkg.
`ifndef P1BC_DEFINES_SVH
`define P1BC_DEFINES_SVH
`define P1BC_ADDR_W          8
`define P1BC_OFF_BASIC       8'h4c
`define P1BC_OFF_CTRL4       8'h4a
`define P1BC_OFF_STATUS      8'h4e
`define P1BC_BC_LOOP         14
`define P1BC_BC_SPEED        13
`define P1BC_BC_ANEN         12
`define P1BC_BC_PDOWN        11
`define P1BC_BC_RESTART      9
`define P1BC_BC_DUPLEX       8
`define P1BC_BC_XSTYLE       5
`define P1BC_BC_FMDIX        4
`define P1BC_BC_NOAUTOX      3
`define P1BC_BC_NOFEF        2
`define P1BC_BC_NOTX         1
`define P1BC_BC_RSVD0        0
`define P1BC_C4_LOOP         8
`define P1BC_C4_SPEED        6
`define P1BC_C4_ANEN         7
`define P1BC_C4_PDOWN        11
`define P1BC_C4_RESTART      13
`define P1BC_C4_DUPLEX       5
`define P1BC_C4_FMDIX        9
`define P1BC_C4_NOAUTOX      10
`define P1BC_C4_NOFEF        12
`define P1BC_C4_NOTX         14
`define P1BC_ST_XSTYLE       15
`define P1BC_ST_LINK         5
`define P1BC_ST_ANDONE       6
`define P1BC_ST_FEF          8
`define P1BC_RST_SPEED       1'b1
`define P1BC_RST_ANEN        1'b1
`define P1BC_RST_DUPLEX      1'b1
`define P1BC_RST_XSTYLE      1'b1
`endif

// *** hw/p1bc_pkg.sv ***
// Purpose: Types shared by the port 1 basic control bank.
// Assumes: Offsets and fields come from p1bc_defines.svh.
// Notes:   One storage bit per control except restart, whose views read the bit in p1bc_restart_pulse.
package p1bc_pkg;
    typedef struct packed {
        logic loopback;
        logic speed_100;
        logic an_enable;
        logic power_down;
        logic an_restart;
        logic full_duplex;
        logic xstyle_first;
        logic force_mdix;
        logic no_auto_x;
        logic no_fef;
        logic tx_disable;
        logic rsvd0;
    } p1bc_ctrl_t;

    typedef struct packed {
        logic        link_up;
        logic        an_done;
        logic        an_failed;
        logic        fef_seen;
    } p1bc_phy_stat_t;

    typedef struct packed {
        logic speed_100;
        logic full_duplex;
    } p1bc_mode_t;
endpackage

// *** hw/p1bc_restart_pulse.sv ***
// Purpose: Self-clearing restart bit that emits one restart pulse to the PHY.
// Assumes: Set and PHY acknowledge are in the core_clk domain.
// Notes:   The bit stays set until the PHY acknowledges the restart.
`timescale 1ns/1ps
module p1bc_restart_pulse (
    input  wire logic core_clk,     // Core clock.
    input  wire logic rst_b,        // Synchronous reset, active low.
    input  wire logic set_req,      // Software wrote a one.
    input  wire logic phy_ack,      // PHY has begun negotiating.
    output logic      restart_bit,  // Readable self-clearing bit.
    output logic      restart_go    // One-cycle restart pulse.
);
    logic next_restart_bit;

    always_comb
    begin
        // A new request in the acknowledge cycle keeps the bit set.
        next_restart_bit = set_req | (restart_bit & ~phy_ack);
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            restart_bit <= 1'b0;
        else
            restart_bit <= next_restart_bit;
    end

    assign restart_go = set_req & ~restart_bit;

    restart_clears_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        restart_bit && phy_ack && !set_req |=> !restart_bit)
        else $error("restart bit not self-cleared");
endmodule // p1bc_restart_pulse

// *** hw/p1bc_basic_control.sv ***
// Purpose: Port 1 PHY basic control register and its alias views.
// Assumes: Host register port with 16-bit data and byte enables in core_clk domain.
// Notes:   Control 4 and status bit views share storage with the basic view.
// Behaviour
// - Bit 14 loops port 2 traffic at port 1 PHY; aliases control four bit 8.
// - Bit 13 resets 1; forced 100 Mbps when one, 10 when zero.
// - Bit 12 resets 1, enables auto-negotiation; aliases control four bit 7.
// - Bit 11 powers down port 1 PHY; aliases control four bit 11.
// - Writing 1 to bit 9 restarts negotiation, then self-clears; zero ignored.
// - Bit 8 resets 1; forced full duplex when one, half when zero.
// - Negotiation enabled but failed always gives half duplex.
// - Bit 5 resets 1, selects crossover style; aliases status bit 15.
// - Bit 4 forces crossed MDI-X pin assignment; aliases control four bit 9.
// - Bit 3 disables automatic crossover detection; aliases control four bit 10.
// - Bit 2 disables far-end-fault detection for fiber; aliases control four bit 12.
// - Bit 1 stops port 1 transmitter; aliases control four bit 14.
// - Bits 15, 10, 7 and 6 are read-only zero.
`timescale 1ns/1ps
`include "p1bc_defines.svh"
module p1bc_basic_control (
    input  wire logic                       core_clk,   // Core clock, 200 MHz.
    input  wire logic                       rst_b,      // Synchronous reset, active low.
    input  wire logic [`P1BC_ADDR_W-1:0]    reg_addr,   // Register byte address.
    input  wire logic                       reg_wr,     // Write strobe.
    input  wire logic                       reg_rd,     // Read strobe.
    input  wire logic [1:0]                 reg_be,     // Byte enables.
    input  wire logic [15:0]                reg_wdata,  // Write data.
    output logic      [15:0]                reg_rdata,  // Read data, registered.
    output logic                            reg_hit,    // Address is one of the views.
    input  wire p1bc_pkg::p1bc_phy_stat_t   phy_stat,   // PHY status, same clock.
    input  wire logic                       phy_an_ack, // PHY took the restart.
    output p1bc_pkg::p1bc_ctrl_t            ctrl,       // Control bits to the PHY.
    output p1bc_pkg::p1bc_mode_t            mode,       // Resolved speed and duplex.
    output logic                            an_restart  // One-cycle restart pulse.
);
    p1bc_pkg::p1bc_ctrl_t next_ctrl;
    p1bc_pkg::p1bc_mode_t next_mode;
    logic [15:0]          next_rdata;
    logic                 restart_req;
    logic                 restart_bit;
    logic [15:0]          wmask;
    logic                 wr_basic;
    logic                 wr_c4;
    logic                 wr_st;

    function automatic logic upd(input logic cur, input logic [15:0] m,
                                 input logic [15:0] d, input int pos);
        upd = m[pos] ? d[pos] : cur;
    endfunction

    assign wmask    = {{8{reg_be[1]}}, {8{reg_be[0]}}};
    assign wr_basic = reg_wr && reg_addr == `P1BC_OFF_BASIC;
    assign wr_c4    = reg_wr && reg_addr == `P1BC_OFF_CTRL4;
    assign wr_st    = reg_wr && reg_addr == `P1BC_OFF_STATUS;
    assign reg_hit  = reg_addr == `P1BC_OFF_BASIC || reg_addr == `P1BC_OFF_CTRL4 ||
                      reg_addr == `P1BC_OFF_STATUS;

    assign restart_req = (wr_basic && wmask[`P1BC_BC_RESTART] &&
                          reg_wdata[`P1BC_BC_RESTART]) ||
                         (wr_c4 && wmask[`P1BC_C4_RESTART] &&
                          reg_wdata[`P1BC_C4_RESTART]);

    p1bc_restart_pulse u_restart (
        .core_clk    (core_clk),
        .rst_b       (rst_b),
        .set_req     (restart_req),
        .phy_ack     (phy_an_ack),
        .restart_bit (restart_bit),
        .restart_go  (an_restart)
    );

    always_comb
    begin
        next_ctrl = ctrl;
        if (wr_basic)
        begin
            next_ctrl.loopback     = upd(ctrl.loopback, wmask, reg_wdata, `P1BC_BC_LOOP);
            next_ctrl.speed_100    = upd(ctrl.speed_100, wmask, reg_wdata, `P1BC_BC_SPEED);
            next_ctrl.an_enable    = upd(ctrl.an_enable, wmask, reg_wdata, `P1BC_BC_ANEN);
            next_ctrl.power_down   = upd(ctrl.power_down, wmask, reg_wdata, `P1BC_BC_PDOWN);
            next_ctrl.full_duplex  = upd(ctrl.full_duplex, wmask, reg_wdata, `P1BC_BC_DUPLEX);
            next_ctrl.xstyle_first = upd(ctrl.xstyle_first, wmask, reg_wdata, `P1BC_BC_XSTYLE);
            next_ctrl.force_mdix   = upd(ctrl.force_mdix, wmask, reg_wdata, `P1BC_BC_FMDIX);
            next_ctrl.no_auto_x    = upd(ctrl.no_auto_x, wmask, reg_wdata, `P1BC_BC_NOAUTOX);
            next_ctrl.no_fef       = upd(ctrl.no_fef, wmask, reg_wdata, `P1BC_BC_NOFEF);
            next_ctrl.tx_disable   = upd(ctrl.tx_disable, wmask, reg_wdata, `P1BC_BC_NOTX);
            next_ctrl.rsvd0        = upd(ctrl.rsvd0, wmask, reg_wdata, `P1BC_BC_RSVD0);
        end
        else if (wr_c4)
        begin
            next_ctrl.loopback     = upd(ctrl.loopback, wmask, reg_wdata, `P1BC_C4_LOOP);
            next_ctrl.speed_100    = upd(ctrl.speed_100, wmask, reg_wdata, `P1BC_C4_SPEED);
            next_ctrl.an_enable    = upd(ctrl.an_enable, wmask, reg_wdata, `P1BC_C4_ANEN);
            next_ctrl.power_down   = upd(ctrl.power_down, wmask, reg_wdata, `P1BC_C4_PDOWN);
            next_ctrl.full_duplex  = upd(ctrl.full_duplex, wmask, reg_wdata, `P1BC_C4_DUPLEX);
            next_ctrl.force_mdix   = upd(ctrl.force_mdix, wmask, reg_wdata, `P1BC_C4_FMDIX);
            next_ctrl.no_auto_x    = upd(ctrl.no_auto_x, wmask, reg_wdata, `P1BC_C4_NOAUTOX);
            next_ctrl.no_fef       = upd(ctrl.no_fef, wmask, reg_wdata, `P1BC_C4_NOFEF);
            next_ctrl.tx_disable   = upd(ctrl.tx_disable, wmask, reg_wdata, `P1BC_C4_NOTX);
        end
        else if (wr_st)
        begin
            next_ctrl.xstyle_first = upd(ctrl.xstyle_first, wmask, reg_wdata, `P1BC_ST_XSTYLE);
        end
        next_ctrl.an_restart = restart_req | (restart_bit & ~phy_an_ack);
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            ctrl              <= '0;
            ctrl.speed_100    <= `P1BC_RST_SPEED;
            ctrl.an_enable    <= `P1BC_RST_ANEN;
            ctrl.full_duplex  <= `P1BC_RST_DUPLEX;
            ctrl.xstyle_first <= `P1BC_RST_XSTYLE;
        end
        else
        begin
            ctrl <= next_ctrl;
        end
    end

    always_comb
    begin
        next_mode = '0;
        if (!ctrl.an_enable)
        begin
            next_mode.speed_100   = ctrl.speed_100;
            next_mode.full_duplex = ctrl.full_duplex;
        end
        else
        begin
            next_mode.speed_100   = ctrl.speed_100;
            next_mode.full_duplex = phy_stat.an_done && !phy_stat.an_failed &&
                                    ctrl.full_duplex;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            mode <= '0;
        else
            mode <= next_mode;
    end

    always_comb
    begin
        next_rdata = 16'h0000;
        if (reg_addr == `P1BC_OFF_BASIC)
        begin
            next_rdata[`P1BC_BC_LOOP]    = ctrl.loopback;
            next_rdata[`P1BC_BC_SPEED]   = ctrl.speed_100;
            next_rdata[`P1BC_BC_ANEN]    = ctrl.an_enable;
            next_rdata[`P1BC_BC_PDOWN]   = ctrl.power_down;
            next_rdata[`P1BC_BC_RESTART] = restart_bit;
            next_rdata[`P1BC_BC_DUPLEX]  = ctrl.full_duplex;
            next_rdata[`P1BC_BC_XSTYLE]  = ctrl.xstyle_first;
            next_rdata[`P1BC_BC_FMDIX]   = ctrl.force_mdix;
            next_rdata[`P1BC_BC_NOAUTOX] = ctrl.no_auto_x;
            next_rdata[`P1BC_BC_NOFEF]   = ctrl.no_fef;
            next_rdata[`P1BC_BC_NOTX]    = ctrl.tx_disable;
            next_rdata[`P1BC_BC_RSVD0]   = ctrl.rsvd0;
        end
        else if (reg_addr == `P1BC_OFF_CTRL4)
        begin
            next_rdata[`P1BC_C4_LOOP]    = ctrl.loopback;
            next_rdata[`P1BC_C4_SPEED]   = ctrl.speed_100;
            next_rdata[`P1BC_C4_ANEN]    = ctrl.an_enable;
            next_rdata[`P1BC_C4_PDOWN]   = ctrl.power_down;
            next_rdata[`P1BC_C4_RESTART] = restart_bit;
            next_rdata[`P1BC_C4_DUPLEX]  = ctrl.full_duplex;
            next_rdata[`P1BC_C4_FMDIX]   = ctrl.force_mdix;
            next_rdata[`P1BC_C4_NOAUTOX] = ctrl.no_auto_x;
            next_rdata[`P1BC_C4_NOFEF]   = ctrl.no_fef;
            next_rdata[`P1BC_C4_NOTX]    = ctrl.tx_disable;
        end
        else if (reg_addr == `P1BC_OFF_STATUS)
        begin
            next_rdata[`P1BC_ST_XSTYLE]  = ctrl.xstyle_first;
            next_rdata[`P1BC_ST_FEF]     = phy_stat.fef_seen & ~ctrl.no_fef;
            next_rdata[`P1BC_ST_ANDONE]  = phy_stat.an_done;
            next_rdata[`P1BC_ST_LINK]    = phy_stat.link_up;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
            reg_rdata <= next_rdata;
    end

    reserved_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $past(reg_rd) && $past(reg_addr) == `P1BC_OFF_BASIC |->
        reg_rdata[15] == 1'b0 && reg_rdata[10] == 1'b0 &&
        reg_rdata[7] == 1'b0 && reg_rdata[6] == 1'b0)
        else $error("reserved basic bits read nonzero");

    alias_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_c4 && reg_be[0] |=> ctrl.speed_100 == $past(reg_wdata[`P1BC_C4_SPEED]))
        else $error("control four write missed shared bit");

    failed_half_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        ctrl.an_enable && phy_stat.an_failed |=> !mode.full_duplex)
        else $error("failed negotiation not half duplex");

    forced_duplex_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !ctrl.an_enable |=> mode.full_duplex == $past(ctrl.full_duplex))
        else $error("forced duplex not applied");

    forced_speed_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !ctrl.an_enable |=> mode.speed_100 == $past(ctrl.speed_100))
        else $error("forced speed not applied");

    restart_go_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        restart_req && !restart_bit |-> an_restart ##1 restart_bit)
        else $error("restart write gave no pulse");

    tx_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_basic && reg_be[0] && reg_wdata[`P1BC_BC_NOTX] |=> ctrl.tx_disable)
        else $error("transmit disable not stored");

    style_alias_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_st && reg_be[1] |=> ctrl.xstyle_first == $past(reg_wdata[`P1BC_ST_XSTYLE]))
        else $error("status alias write missed style bit");
endmodule // p1bc_basic_control

// *** test/p1bc_basic_control_bench.sv ***
// Purpose: Self-checking bench for the port 1 basic control bank.
// Assumes: Host strobes are one-cycle pulses; read data lands one edge after the strobe.
// Notes:   Scenarios run back to back, so each starts from the state the last one left.
`timescale 1ns/1ps
`include "p1bc_defines.svh"
module p1bc_basic_control_bench;
    logic                     core_clk;
    logic                     rst_b;
    logic [7:0]               reg_addr;
    logic                     reg_wr;
    logic                     reg_rd;
    logic [1:0]               reg_be;
    logic [15:0]              reg_wdata;
    logic [15:0]              reg_rdata;
    logic                     reg_hit;
    p1bc_pkg::p1bc_phy_stat_t phy_stat;
    logic                     phy_an_ack;
    p1bc_pkg::p1bc_ctrl_t     ctrl;
    p1bc_pkg::p1bc_mode_t     mode;
    logic                     an_restart;
    logic                     last_pulse;
    int                       n_errors;
    int                       comparisons;

    always #2.5 core_clk = ~core_clk;

    p1bc_basic_control DUT (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .reg_addr   (reg_addr),
        .reg_wr     (reg_wr),
        .reg_rd     (reg_rd),
        .reg_be     (reg_be),
        .reg_wdata  (reg_wdata),
        .reg_rdata  (reg_rdata),
        .reg_hit    (reg_hit),
        .phy_stat   (phy_stat),
        .phy_an_ack (phy_an_ack),
        .ctrl       (ctrl),
        .mode       (mode),
        .an_restart (an_restart)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // The restart pulse is combinational, so it is sampled inside the strobe cycle.
    task automatic wr(input logic [7:0] addr, input logic [1:0] be, input logic [15:0] data);
        @(posedge core_clk);
        reg_addr  <= addr;
        reg_be    <= be;
        reg_wdata <= data;
        reg_wr    <= 1'b1;
        #1 last_pulse = an_restart;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] addr, input logic [15:0] exp, input string what);
        @(posedge core_clk);
        reg_addr <= addr;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp, what);
    endtask

    task automatic test_reset;
        rchk(`P1BC_OFF_BASIC, 16'h3120, "basic reset value");
        chk({15'h0, reg_hit}, 16'h0001, "basic view hit");
        chk({4'h0, ctrl}, 16'h0660, "ctrl after reset");
    endtask

    task automatic test_write_all;
        wr(`P1BC_OFF_BASIC, 2'b11, 16'hfdff);
        rchk(`P1BC_OFF_BASIC, 16'h793f, "read-only bits stay zero");
        chk({4'h0, ctrl}, 16'h0f7f, "ctrl levels set");
    endtask

    task automatic test_alias;
        rchk(`P1BC_OFF_CTRL4, 16'h5fe0, "control four view");
        rchk(`P1BC_OFF_STATUS, 16'h8000, "status view style bit");
        wr(`P1BC_OFF_CTRL4, 2'b11, 16'h0000);
        rchk(`P1BC_OFF_BASIC, 16'h0021, "cleared through control four");
        wr(`P1BC_OFF_STATUS, 2'b11, 16'h0000);
        rchk(`P1BC_OFF_BASIC, 16'h0001, "style cleared through status");
        wr(`P1BC_OFF_BASIC, 2'b10, 16'hfdff);
        rchk(`P1BC_OFF_BASIC, 16'h7901, "upper byte only");
    endtask

    task automatic test_restart;
        wr(`P1BC_OFF_BASIC, 2'b11, 16'h0200);
        chk({15'h0, last_pulse}, 16'h0001, "restart pulse");
        rchk(`P1BC_OFF_BASIC, 16'h0200, "restart pending");
        chk({15'h0, ctrl.an_restart}, 16'h0001, "restart mirrored");
        wr(`P1BC_OFF_BASIC, 2'b11, 16'h0200);
        chk({15'h0, last_pulse}, 16'h0000, "no pulse while pending");
        @(posedge core_clk);
        phy_an_ack <= 1'b1;
        @(posedge core_clk);
        phy_an_ack <= 1'b0;
        rchk(`P1BC_OFF_BASIC, 16'h0000, "restart self-cleared");
        wr(`P1BC_OFF_BASIC, 2'b11, 16'h0000);
        chk({15'h0, last_pulse}, 16'h0000, "zero write no pulse");
    endtask

    task automatic test_mode;
        logic [15:0] forced [4];
        forced = '{16'h0000, 16'h2100, 16'h2000, 16'h0100};
        for (int i = 0; i < 4; i++)
        begin
            wr(`P1BC_OFF_BASIC, 2'b11, forced[i]);
            repeat (2) @(posedge core_clk);
            #1 chk({14'h0, mode}, {14'h0, forced[i][13], forced[i][8]}, "forced mode");
        end
        @(posedge core_clk);
        phy_stat <= 4'b0010;
        wr(`P1BC_OFF_BASIC, 2'b11, 16'h1100);
        repeat (2) @(posedge core_clk);
        #1 chk({15'h0, mode.full_duplex}, 16'h0000, "failed negotiation half");
        @(posedge core_clk);
        phy_stat <= 4'b1101;
        repeat (3) @(posedge core_clk);
        #1 chk({15'h0, mode.full_duplex}, 16'h0001, "negotiated full");
        rchk(`P1BC_OFF_STATUS, 16'h0160, "status live bits with fault");
    endtask

    task automatic test_unmapped;
        wr(8'h50, 2'b11, 16'hffff);
        rchk(8'h50, 16'h0000, "unmapped read");
        chk({15'h0, reg_hit}, 16'h0000, "unmapped hit");
        rchk(`P1BC_OFF_BASIC, 16'h1100, "basic untouched");
    endtask

    task automatic report_and_stop;
        $display("Errors: %0d  Comparisons: %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        core_clk    = 1'b0;
        rst_b       = 1'b0;
        reg_addr    = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        reg_be      = 2'h0;
        reg_wdata   = 16'h0000;
        phy_stat    = 4'h0;
        phy_an_ack  = 1'b0;
        last_pulse  = 1'b0;
        n_errors    = 0;
        comparisons = 0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        test_reset();
        test_write_all();
        test_alias();
        test_restart();
        test_mode();
        test_unmapped();
        report_and_stop();
    end

    // The scenarios need about 70 cycles; 4000 leaves ample margin.
    initial
    begin
        #20000;
        n_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule // p1bc_basic_control_bench
